// File: ccd_timing_pkg.sv
// Constants and types shared by the sensor readout timing generator
package ccd_timing_pkg;
  // System clock
  localparam int CLK_PERIOD_NS = 4;
  // Pulse and settle times in ns
  localparam int SHUTTER_PULSE_NS       = 4000;
  localparam int TRANSFER_PULSE_NS      = 10000;
  localparam int VERT_SETTLE_NS         = 1000;
  localparam int LINE_SHIFT_TO_HORIZ_NS = 1000;
  localparam int ROW_SHIFT_PULSE_NS     = 1000;
  // Least times round up to whole cycles
  localparam int SHUTTER_CYC  = (SHUTTER_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRANSFER_CYC = (TRANSFER_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC   = (VERT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINE_GAP_CYC = (LINE_SHIFT_TO_HORIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_PULSE_CYC = (ROW_SHIFT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Line layout of the horizontal register
  localparam int EMPTY_PIX       = 8;
  localparam int DARK_PIX        = 12;
  localparam int IMAGE_PIX_SINGLE = 1004;
  localparam int IMAGE_PIX_DUAL  = 502;
  localparam int LINE_CYC_SINGLE = 1028;
  localparam int LINE_CYC_DUAL   = 523;
  localparam int CDS_DELAY       = 1;
  localparam int DARK_EDGE_SKIP  = 1;
  // Output routing
  typedef enum logic [1:0] {
    MODE_OUT1 = 2'h0,
    MODE_OUT2 = 2'h1,
    MODE_DUAL = 2'h2
  } out_mode_t;
  // Sequencer states, one-hot
  typedef enum logic [9:0] {
    S_IDLE     = 10'h001,
    S_SHUTTER  = 10'h002,
    S_EXPOSE   = 10'h004,
    S_LEAD     = 10'h008,
    S_XFER     = 10'h010,
    S_POST     = 10'h020,
    S_HALT     = 10'h040,
    S_ROWSHIFT = 10'h080,
    S_GAP      = 10'h100,
    S_HCLK     = 10'h200
  } seq_state_t;
endpackage : ccd_timing_pkg

// File: ccd_interval_timer.sv
// Loadable down counter that times each sequencer state except idle, halt and line clocking
`timescale 1ns/1ns
module ccd_interval_timer #(
  parameter int TW = 32
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_load,
  input  wire logic [TW-1:0] i_count,
  output logic      [TW-1:0] o_left,
  output logic               o_last
);
  if (TW < 16)
  begin : g_bad_width
    $error("ccd_interval_timer: TW too small for the pulse counts");
  end

  logic [TW-1:0] cnt_q;
  logic [TW-1:0] cnt_d;

  // Counts down to one, then holds; zero means idle
  always_comb
  begin
    cnt_d = cnt_q;
    if (i_load)
      cnt_d = i_count;
    else if (cnt_q > TW'(1))
      cnt_d = cnt_q - TW'(1);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign o_left = cnt_q;
  assign o_last = (cnt_q == TW'(1));
endmodule : ccd_interval_timer

// File: ccd_hclk_gen.sv
// Horizontal clock pair and sampling clock divided down from the system clock
`timescale 1ns/1ns
module ccd_hclk_gen #(
  parameter int HALF = 4,
  parameter int CW   = 11
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_run,
  input  wire logic          i_clear,
  output logic               o_clk_a,
  output logic               o_clk_b,
  output logic               o_cds,
  output logic               o_halted,
  output logic               o_cycle_end,
  output logic      [CW-1:0] o_count
);
  localparam int DW = (HALF > 1) ? $clog2(HALF) : 1;

  if (HALF < 1 || CW < 11)
  begin : g_bad_param
    $error("ccd_hclk_gen: HALF must be at least 1 and CW at least 11");
  end

  logic [DW-1:0] div_q, div_d;
  logic          phase_q, phase_d;
  logic          halted_q, halted_d;
  logic          cds_q, cds_d;
  logic          end_q, end_d;
  logic          a_q, a_d;
  logic          b_q, b_d;
  logic [CW-1:0] count_q, count_d;
  logic          tick;

  assign tick = (div_q == DW'(HALF - 1));

  // Stops only at a cycle boundary so the pair never glitches
  always_comb
  begin
    div_d    = tick ? '0 : div_q + DW'(1);
    cds_d    = tick ? ~cds_q : cds_q;
    phase_d  = phase_q;
    halted_d = halted_q;
    end_d    = 1'b0;
    count_d  = i_clear ? '0 : count_q;
    if (tick)
    begin
      if (halted_q)
      begin
        if (i_run)
        begin
          halted_d = 1'b0;
          phase_d  = 1'b1;
        end
      end
      else if (phase_q)
        phase_d = 1'b0;
      else
      begin
        end_d   = 1'b1;
        count_d = count_q + CW'(1);
        if (i_run)
          phase_d = 1'b1;
        else
          halted_d = 1'b1;
      end
    end
    a_d = halted_d | ~phase_d;  // Parks high
    b_d = ~halted_d & phase_d;  // Parks low
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_q    <= '0;
      phase_q  <= 1'b0;
      halted_q <= 1'b1;
      cds_q    <= 1'b0;
      end_q    <= 1'b0;
      a_q      <= 1'b1;
      b_q      <= 1'b0;
      count_q  <= '0;
    end
    else
    begin
      div_q    <= div_d;
      phase_q  <= phase_d;
      halted_q <= halted_d;
      cds_q    <= cds_d;
      end_q    <= end_d;
      a_q      <= a_d;
      b_q      <= b_d;
      count_q  <= count_d;
    end
  end

  assign o_clk_a     = a_q;
  assign o_clk_b     = b_q;
  assign o_cds       = cds_q;
  assign o_halted    = halted_q;
  assign o_cycle_end = end_q;
  assign o_count     = count_q;
endmodule : ccd_hclk_gen

// File: ccd_readout_ctrl.sv
// Timing generator that drives an interline sensor through capture and readout
// How it works
// - Shutter pulse empties photodiodes, exposure starts
// - Transfer pulse on phase-2 ends exposure
// - Frame sequence starts only after last pixel
// - Settle, transfer with phase-1, settle again
// - Horizontal and sampling clocks run during frame
// - Short exposure puts shutter inside frame sequence
// - Row shift halts clock A high, B low
// - Horizontal clocking waits line gap after shift
// - Sampling clock keeps toggling every line
// - Black level from central ten dark columns
// - Vertical, shutter, dump pins low during pixels
// - Output one routing of half phases
// - Output two routing of half phases
// - Single output needs 1028 cycles per line
// - Dual routing: both halves to own outputs
// - Dual: 502 image pixels, 523 cycles
`timescale 1ns/1ns
module ccd_readout_ctrl #(
  parameter int ROWS  = 1008,
  parameter int RW    = 11,
  parameter int H_HALF = 4,
  parameter int TW    = 32
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_start,
  input  wire logic [1:0]    i_mode,
  input  wire logic [TW-1:0] i_exposure_cycles,
  input  wire logic [RW-1:0] i_dump_rows,
  output logic               o_shutter_trigger,
  output logic               o_vert_phase2_shift,
  output logic               o_vert_phase2_transfer,
  output logic               o_vert_phase1,
  output logic               o_row_dump,
  output logic               o_horiz_clock_a,
  output logic               o_horiz_clock_b,
  output logic               o_left_half_phase1,
  output logic               o_left_half_phase2,
  output logic               o_right_half_phase1,
  output logic               o_right_half_phase2,
  output logic               o_cds_clock,
  output logic               o_pixel_valid,
  output logic               o_dark_valid,
  output logic               o_line_done,
  output logic               o_frame_done,
  output logic               o_busy
);
  localparam int CW = 11;
  localparam int LEAD_SPAN = ccd_timing_pkg::SETTLE_CYC + ccd_timing_pkg::TRANSFER_CYC;
  localparam int IMG_LO = ccd_timing_pkg::EMPTY_PIX + ccd_timing_pkg::DARK_PIX;

  if (ROWS < 1 || ROWS >= (1 << RW) || H_HALF < 1 || TW < 16)
  begin : g_bad_param
    $error("ccd_readout_ctrl: parameter values out of range");
  end

  ccd_timing_pkg::seq_state_t state_q, state_d;
  ccd_timing_pkg::out_mode_t  mode_q, mode_d;
  logic [TW-1:0] expo_q, expo_d;
  logic          short_q, short_d;
  logic [RW-1:0] row_q, row_d;
  logic [RW-1:0] dump_q, dump_d;
  logic          line_q, line_d;
  logic          t_load;
  logic [TW-1:0] t_val;
  logic [TW-1:0] t_left;
  logic          t_last;
  logic          h_run;
  logic          h_clear;
  logic          h_a, h_b, h_cds, h_halted, h_end;
  logic [CW-1:0] h_count;
  logic [CW-1:0] line_cyc;
  logic          frame_end;

  ccd_interval_timer #(
    .TW(TW)
  ) u_timer (
    .i_clk   (i_clk),
    .i_resetn(i_resetn),
    .i_load  (t_load),
    .i_count (t_val),
    .o_left  (t_left),
    .o_last  (t_last)
  );

  ccd_hclk_gen #(
    .HALF(H_HALF),
    .CW  (CW)
  ) u_hclk (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_run      (h_run),
    .i_clear    (h_clear),
    .o_clk_a    (h_a),
    .o_clk_b    (h_b),
    .o_cds      (h_cds),
    .o_halted   (h_halted),
    .o_cycle_end(h_end),
    .o_count    (h_count)
  );

  // Clocks run everywhere except around a row shift
  assign h_run = !(state_q inside {ccd_timing_pkg::S_HALT, ccd_timing_pkg::S_ROWSHIFT,
                                   ccd_timing_pkg::S_GAP});
  assign line_cyc = (mode_q == ccd_timing_pkg::MODE_DUAL) ?
                    CW'(ccd_timing_pkg::LINE_CYC_DUAL) :
                    CW'(ccd_timing_pkg::LINE_CYC_SINGLE);

  // Sequencer: capture, frame transfer, then one line per row that is not dumped
  always_comb
  begin
    state_d   = state_q;
    mode_d    = mode_q;
    expo_d    = expo_q;
    short_d   = short_q;
    row_d     = row_q;
    dump_d    = dump_q;
    h_clear   = 1'b0;
    frame_end = 1'b0;
    unique case (state_q)
      ccd_timing_pkg::S_IDLE:
        if (i_start)
        begin
          mode_d  = ccd_timing_pkg::out_mode_t'(i_mode);
          expo_d  = (i_exposure_cycles == '0) ? TW'(1) : i_exposure_cycles;
          short_d = (expo_d <= TW'(LEAD_SPAN));
          dump_d  = i_dump_rows;
          row_d   = '0;
          state_d = short_d ? ccd_timing_pkg::S_LEAD : ccd_timing_pkg::S_SHUTTER;
        end
      ccd_timing_pkg::S_SHUTTER:
        if (t_last)
          state_d = ccd_timing_pkg::S_EXPOSE;
      ccd_timing_pkg::S_EXPOSE:
        if (t_last)
          state_d = ccd_timing_pkg::S_LEAD;
      ccd_timing_pkg::S_LEAD:
        if (t_last)
          state_d = ccd_timing_pkg::S_XFER;
      ccd_timing_pkg::S_XFER:
        if (t_last)
          state_d = ccd_timing_pkg::S_POST;
      ccd_timing_pkg::S_POST:
        if (t_last)
          state_d = ccd_timing_pkg::S_HALT;
      ccd_timing_pkg::S_HALT:
        if (h_halted)
          state_d = ccd_timing_pkg::S_ROWSHIFT;
      ccd_timing_pkg::S_ROWSHIFT:
        if (t_last)
          state_d = ccd_timing_pkg::S_GAP;
      ccd_timing_pkg::S_GAP:
        if (t_last)
        begin
          if (row_q < dump_q)
            frame_end = (row_q == RW'(ROWS - 1));
          else
          begin
            h_clear = 1'b1;
            state_d = ccd_timing_pkg::S_HCLK;
          end
        end
      ccd_timing_pkg::S_HCLK:
        if (h_end && h_count == line_cyc)
          frame_end = (row_q == RW'(ROWS - 1));
    endcase
    // Row finished: next row or back to idle
    if ((state_q == ccd_timing_pkg::S_GAP && t_last && row_q < dump_q) ||
        (state_q == ccd_timing_pkg::S_HCLK && h_end && h_count == line_cyc))
    begin
      row_d   = row_q + RW'(1);
      state_d = frame_end ? ccd_timing_pkg::S_IDLE : ccd_timing_pkg::S_HALT;
    end
  end

  // Timer loads on every state change with the new state's length
  always_comb
  begin
    t_load = (state_d != state_q);
    t_val  = TW'(1);
    unique case (state_d)
      ccd_timing_pkg::S_SHUTTER:  t_val = TW'(ccd_timing_pkg::SHUTTER_CYC);
      ccd_timing_pkg::S_EXPOSE:   t_val = expo_d - TW'(LEAD_SPAN);
      ccd_timing_pkg::S_LEAD:
        t_val = short_d ? TW'(ccd_timing_pkg::SETTLE_CYC + ccd_timing_pkg::SHUTTER_CYC) :
                          TW'(ccd_timing_pkg::SETTLE_CYC);
      ccd_timing_pkg::S_XFER:     t_val = TW'(ccd_timing_pkg::TRANSFER_CYC);
      ccd_timing_pkg::S_POST:     t_val = TW'(ccd_timing_pkg::SETTLE_CYC);
      ccd_timing_pkg::S_ROWSHIFT: t_val = TW'(ccd_timing_pkg::ROW_PULSE_CYC);
      ccd_timing_pkg::S_GAP:      t_val = TW'(ccd_timing_pkg::LINE_GAP_CYC);
      default:                    t_val = TW'(1);
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= ccd_timing_pkg::S_IDLE;
      mode_q  <= ccd_timing_pkg::MODE_OUT1;
      expo_q  <= '0;
      short_q <= 1'b0;
      row_q   <= '0;
      dump_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      mode_q  <= mode_d;
      expo_q  <= expo_d;
      short_q <= short_d;
      row_q   <= row_d;
      dump_q  <= dump_d;
    end
  end

  // Pin and strobe values, all registered
  logic [TW-1:0] to_end;
  logic [CW-1:0] pix;
  logic shut_d, shift_d, xfer_d, ph1_d, rdump_d, a_d, b_d, l1_d, l2_d, r1_d, r2_d;
  logic pv_d, dv_d, ld_d, fdone_d;
  logic shut_q, shift_q, xfer_q, ph1_q, rdump_q, a_q, b_q, l1_q, l2_q, r1_q, r2_q, cds_q;
  logic pv_q, dv_q, ld_q, fdone_q, busy_q;

  always_comb
  begin
    to_end = '0;
    if (state_q == ccd_timing_pkg::S_LEAD)
      to_end = t_left + TW'(ccd_timing_pkg::TRANSFER_CYC);
    else if (state_q == ccd_timing_pkg::S_XFER)
      to_end = t_left;
    // Short exposure: shutter falls exactly expo_q cycles before transfer ends
    shut_d = (state_q == ccd_timing_pkg::S_SHUTTER) ||
             (short_q && to_end > expo_q &&
              to_end <= expo_q + TW'(ccd_timing_pkg::SHUTTER_CYC));
    shift_d = (state_q == ccd_timing_pkg::S_LEAD) || (state_q == ccd_timing_pkg::S_XFER) ||
              (state_q == ccd_timing_pkg::S_ROWSHIFT);
    xfer_d  = (state_q == ccd_timing_pkg::S_XFER);
    ph1_d   = xfer_d || (state_q == ccd_timing_pkg::S_ROWSHIFT);
    rdump_d = (state_q == ccd_timing_pkg::S_ROWSHIFT) && (row_q < dump_q);
    a_d   = h_a;
    b_d   = h_b;
    // Half-register phase routing per output mode
    unique case (mode_q)
      ccd_timing_pkg::MODE_OUT2:
      begin
        l1_d = h_b; l2_d = h_a; r1_d = h_a; r2_d = h_b;
      end
      ccd_timing_pkg::MODE_DUAL:
      begin
        l1_d = h_a; l2_d = h_b; r1_d = h_a; r2_d = h_b;
      end
      default:
      begin
        l1_d = h_a; l2_d = h_b; r1_d = h_b; r2_d = h_a;
      end
    endcase
    // Sampling delay: end of cycle n shows pixel n-2
    line_d = line_q;
    pv_d = 1'b0;
    dv_d = 1'b0;
    ld_d = 1'b0;
    pix  = h_count - CW'(2 * ccd_timing_pkg::CDS_DELAY);
    if (h_clear)
      line_d = 1'b1;
    else if (line_q && h_end)
    begin
      if (h_count >= CW'(2 * ccd_timing_pkg::CDS_DELAY))
      begin
        pv_d = (pix >= CW'(IMG_LO)) &&
               (pix < CW'(IMG_LO + ((mode_q == ccd_timing_pkg::MODE_DUAL) ?
                  ccd_timing_pkg::IMAGE_PIX_DUAL : ccd_timing_pkg::IMAGE_PIX_SINGLE)));
        dv_d = (pix >= CW'(ccd_timing_pkg::EMPTY_PIX + ccd_timing_pkg::DARK_EDGE_SKIP)) &&
               (pix < CW'(IMG_LO - ccd_timing_pkg::DARK_EDGE_SKIP));
      end
      if (state_q != ccd_timing_pkg::S_HCLK)
      begin
        line_d = 1'b0;
        ld_d   = 1'b1;
      end
    end
    fdone_d = (state_q != ccd_timing_pkg::S_IDLE) && (state_d == ccd_timing_pkg::S_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {shut_q, shift_q, xfer_q, ph1_q, rdump_q} <= '0;
      {a_q, b_q} <= 2'h2;
      {l1_q, l2_q, r1_q, r2_q, cds_q} <= '0;
      {pv_q, dv_q, ld_q, fdone_q, busy_q, line_q} <= '0;
    end
    else
    begin
      {shut_q, shift_q, xfer_q, ph1_q, rdump_q} <= {shut_d, shift_d, xfer_d, ph1_d, rdump_d};
      {a_q, b_q} <= {a_d, b_d};
      {l1_q, l2_q, r1_q, r2_q, cds_q} <= {l1_d, l2_d, r1_d, r2_d, h_cds};
      {pv_q, dv_q, ld_q, fdone_q} <= {pv_d, dv_d, ld_d, fdone_d};
      busy_q <= (state_d != ccd_timing_pkg::S_IDLE);
      line_q <= line_d;
    end
  end

  assign o_shutter_trigger      = shut_q;
  assign o_vert_phase2_shift    = shift_q;
  assign o_vert_phase2_transfer = xfer_q;
  assign o_vert_phase1          = ph1_q;
  assign o_row_dump             = rdump_q;
  assign o_horiz_clock_a        = a_q;
  assign o_horiz_clock_b        = b_q;
  assign o_left_half_phase1     = l1_q;
  assign o_left_half_phase2     = l2_q;
  assign o_right_half_phase1    = r1_q;
  assign o_right_half_phase2    = r2_q;
  assign o_cds_clock            = cds_q;
  assign o_pixel_valid          = pv_q;
  assign o_dark_valid           = dv_q;
  assign o_line_done            = ld_q;
  assign o_frame_done           = fdone_q;
  assign o_busy                 = busy_q;

  // Helper counters that only the checks below read
  logic [15:0] shut_len_q, xfer_len_q, shift_len_q, vfall_q;
  logic [CW-1:0] img_q;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {shut_len_q, xfer_len_q, shift_len_q} <= '0;
      vfall_q <= 16'hffff;
      img_q   <= '0;
    end
    else
    begin
      shut_len_q  <= shut_q ? shut_len_q + 16'h1 : 16'h0;
      xfer_len_q  <= xfer_q ? xfer_len_q + 16'h1 : 16'h0;
      shift_len_q <= shift_q ? shift_len_q + 16'h1 : 16'h0;
      // Only a row shift restarts it: clocks may run on right after a transfer
      vfall_q     <= (ph1_q && !xfer_q) ? 16'h0 : vfall_q + 16'(vfall_q != 16'hffff);
      img_q       <= ld_q ? '0 : (pv_q ? img_q + CW'(1) : img_q);
    end
  end

  property p_shutter_width;
    @(posedge i_clk) disable iff (!i_resetn)
      $fell(o_shutter_trigger) |-> shut_len_q == 16'(ccd_timing_pkg::SHUTTER_CYC);
  endproperty
  a_shutter_width: assert property (p_shutter_width) else $error("shutter pulse width wrong");

  property p_transfer_width;
    @(posedge i_clk) disable iff (!i_resetn)
      $fell(o_vert_phase2_transfer) |-> xfer_len_q == 16'(ccd_timing_pkg::TRANSFER_CYC);
  endproperty
  a_transfer_width: assert property (p_transfer_width) else $error("transfer width wrong");

  property p_lead_settle;
    @(posedge i_clk) disable iff (!i_resetn)
      $rose(o_vert_phase2_transfer) |->
        o_vert_phase1 && shift_len_q >= 16'(ccd_timing_pkg::SETTLE_CYC);
  endproperty
  a_lead_settle: assert property (p_lead_settle) else $error("settle before transfer short");

  property p_halt_on_shift;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_vert_phase1 && !o_vert_phase2_transfer) |-> o_horiz_clock_a && !o_horiz_clock_b;
  endproperty
  a_halt_on_shift: assert property (p_halt_on_shift) else $error("clocks run in row shift");

  property p_line_gap;
    @(posedge i_clk) disable iff (!i_resetn)
      $fell(o_horiz_clock_a) |-> vfall_q >= 16'(ccd_timing_pkg::LINE_GAP_CYC);
  endproperty
  a_line_gap: assert property (p_line_gap) else $error("horizontal clock resumed too early");

  property p_quiet_pins;
    @(posedge i_clk) disable iff (!i_resetn)
      o_pixel_valid |-> !(o_shutter_trigger || o_vert_phase2_shift ||
                          o_vert_phase2_transfer || o_vert_phase1 || o_row_dump);
  endproperty
  a_quiet_pins: assert property (p_quiet_pins) else $error("noisy pin during pixel");

  property p_image_count;
    @(posedge i_clk) disable iff (!i_resetn)
      o_line_done |-> img_q == ((mode_q == ccd_timing_pkg::MODE_DUAL) ?
        CW'(ccd_timing_pkg::IMAGE_PIX_DUAL) : CW'(ccd_timing_pkg::IMAGE_PIX_SINGLE));
  endproperty
  a_image_count: assert property (p_image_count) else $error("image pixel count wrong");

  property p_line_length;
    @(posedge i_clk) disable iff (!i_resetn)
      (state_q == ccd_timing_pkg::S_HCLK && state_d != ccd_timing_pkg::S_HCLK) |->
        h_count >= line_cyc ##1 !o_busy || state_q == ccd_timing_pkg::S_HALT;
  endproperty
  a_line_length: assert property (p_line_length) else $error("line too short");
endmodule : ccd_readout_ctrl

// File: ccd_sensor_model.sv
// Behavioural sensor that counts rows and horizontal cycles seen at its pins
`timescale 1ns/1ns
module ccd_sensor_model (
  input  wire logic                 i_vert_phase1,
  input  wire logic                 i_vert_phase2_transfer,
  input  wire logic                 i_row_dump,
  input  wire logic                 i_horiz_clock_a,
  input  wire logic                 i_left_half_phase1,
  input  wire logic                 i_left_half_phase2,
  input  wire logic                 i_right_half_phase1,
  input  wire logic                 i_right_half_phase2,
  output int                        o_rows_read,
  output int                        o_rows_dumped,
  output int                        o_min_cycles,
  output ccd_timing_pkg::out_mode_t o_route
);
  int cyc_q = 0;
  bit xfer_pend = 1'b0;
  bit dump_pend = 1'b0;
  bit first_line = 1'b1;
  initial
  begin
    o_rows_read   = 0;
    o_rows_dumped = 0;
    o_min_cycles  = 0;
    o_route       = ccd_timing_pkg::MODE_OUT1;
  end
  // Transfer also raises phase 1, so it must not pass for a row shift
  always @(posedge i_vert_phase2_transfer) xfer_pend = 1'b1;
  always @(posedge i_row_dump) dump_pend = 1'b1;
  // Row move completes on falling phase 1; a dumped row never reaches the register
  always @(negedge i_vert_phase1)
  begin
    if (xfer_pend)
    begin
      xfer_pend    = 1'b0;
      first_line   = 1'b1;
      o_min_cycles = 100000;
    end
    else if (dump_pend)
    begin
      dump_pend     = 1'b0;
      o_rows_dumped = o_rows_dumped + 1;
    end
    else
    begin
      if (!first_line && cyc_q < o_min_cycles) o_min_cycles = cyc_q;
      first_line  = 1'b0;
      o_rows_read = o_rows_read + 1;
      cyc_q       = 0;
    end
  end
  // Each rising clock A ends one cycle; routing is read once the copies have settled
  always @(posedge i_horiz_clock_a)
  begin
    cyc_q = cyc_q + 1;
    #1;
    if (i_left_half_phase1 && i_right_half_phase1) o_route = ccd_timing_pkg::MODE_DUAL;
    else if (i_left_half_phase1 && i_right_half_phase2) o_route = ccd_timing_pkg::MODE_OUT1;
    else if (i_left_half_phase2 && i_right_half_phase1) o_route = ccd_timing_pkg::MODE_OUT2;
  end
endmodule : ccd_sensor_model

// File: tb_top.sv
// Self-checking bench for the readout timing generator
`timescale 1ns/1ns
module tb_top;
  localparam int ROWS = 4;
  logic        i_clk = 1'b0;
  logic        i_resetn, i_start;
  logic [1:0]  i_mode;
  logic [31:0] i_exposure_cycles;
  logic [10:0] i_dump_rows;
  logic        o_shutter_trigger, o_vert_phase2_shift, o_vert_phase2_transfer, o_vert_phase1;
  logic        o_row_dump, o_horiz_clock_a, o_horiz_clock_b, o_cds_clock, o_busy;
  logic        o_left_half_phase1, o_left_half_phase2, o_right_half_phase1, o_right_half_phase2;
  logic        o_pixel_valid, o_dark_valid, o_line_done, o_frame_done, shut_p, xf_p, cds_p;
  int          n_errors = 0, num_checks = 0, cyc = 0, rows_read, rows_dumped, min_cyc;
  int          n_pix, n_dark, n_line, n_done, n_cds, shut_w, xf_w, gap, integ;
  ccd_timing_pkg::out_mode_t route;

  always #2 i_clk = ~i_clk;

  // Short half period keeps each single-output line near four thousand cycles
  ccd_readout_ctrl #(.ROWS(ROWS), .H_HALF(2)) ccd_readout_ctrl_inst (.i_clk, .i_resetn,
    .i_start, .i_mode, .i_exposure_cycles, .i_dump_rows, .o_shutter_trigger,
    .o_vert_phase2_shift, .o_vert_phase2_transfer, .o_vert_phase1, .o_row_dump,
    .o_horiz_clock_a, .o_horiz_clock_b, .o_left_half_phase1, .o_left_half_phase2,
    .o_right_half_phase1, .o_right_half_phase2, .o_cds_clock, .o_pixel_valid,
    .o_dark_valid, .o_line_done, .o_frame_done, .o_busy);

  ccd_sensor_model ccd_sensor_model_inst (.i_vert_phase1(o_vert_phase1),
    .i_vert_phase2_transfer(o_vert_phase2_transfer), .i_row_dump(o_row_dump),
    .i_horiz_clock_a(o_horiz_clock_a), .i_left_half_phase1(o_left_half_phase1),
    .i_left_half_phase2(o_left_half_phase2), .i_right_half_phase1(o_right_half_phase1),
    .i_right_half_phase2(o_right_half_phase2), .o_rows_read(rows_read),
    .o_rows_dumped(rows_dumped), .o_min_cycles(min_cyc), .o_route(route));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Pin monitor: event counts, pulse widths and per-cycle quiet rules
  always @(negedge i_clk)
  begin
    n_pix  += o_pixel_valid;
    n_dark += o_dark_valid;
    n_line += o_line_done;
    n_done += o_frame_done;
    n_cds  += (o_cds_clock != cds_p);
    if (o_shutter_trigger) shut_w = shut_p ? shut_w + 1 : 1;
    if (o_vert_phase2_transfer) xf_w = xf_p ? xf_w + 1 : 1;
    gap = (shut_p && !o_shutter_trigger) ? 0 : gap + 1;
    if (xf_p && !o_vert_phase2_transfer) integ = gap;
    shut_p = o_shutter_trigger;
    xf_p = o_vert_phase2_transfer;
    cds_p = o_cds_clock;
    if (o_vert_phase1 && !o_vert_phase2_transfer) check({o_horiz_clock_a, o_horiz_clock_b}, 2'h2);
    if (o_pixel_valid) check({o_shutter_trigger, o_vert_phase2_shift, o_vert_phase2_transfer,
      o_vert_phase1, o_row_dump}, 5'h00);
  end

  // Hang guard, well above the roughly fifty-three thousand cycles the frames need
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      n_errors++;
      summarize();
    end
  end

  // One whole capture, with a start attempt while busy that must be ignored
  task automatic run_frame(input logic [1:0] m, input int e, input int d,
                           input ccd_timing_pkg::out_mode_t rt, input int hmin, input int img);
    int r0;
    int d0;
    int t;
    r0 = rows_read;
    d0 = rows_dumped;
    {n_pix, n_dark, n_line, n_done, n_cds, t} = '0;
    i_mode = m;
    i_exposure_cycles = e;
    i_dump_rows = d[10:0];
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    repeat (3) @(negedge i_clk);
    check(o_busy, 1'b1);
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    while (n_done == 0 && t < 40000)
    begin
      @(negedge i_clk);
      t++;
    end
    repeat (20) @(negedge i_clk);
    check(o_busy, 1'b0);
    check(n_done, 1);
    check(n_pix, (ROWS - d) * img);
    check(n_dark, (ROWS - d) * 10);
    check(n_line, ROWS - d);
    check(rows_read - r0, ROWS - d);
    check(rows_dumped - d0, d);
    check(route, rt);
    check(min_cyc >= hmin, 1'b1);
    check(shut_w, ccd_timing_pkg::SHUTTER_CYC);
    check(xf_w, ccd_timing_pkg::TRANSFER_CYC);
    check(integ, e);
    check(n_cds >= t / 2, 1'b1);
  endtask : run_frame

  // Reset, then one frame per routing; mode 3 must route as output one
  initial
  begin
    {i_resetn, i_start, i_mode, i_exposure_cycles, i_dump_rows} = '0;
    {shut_w, xf_w, gap, integ} = '0;
    repeat (20) @(negedge i_clk);
    check({o_horiz_clock_a, o_horiz_clock_b, o_busy, o_shutter_trigger}, 4'h8);
    i_resetn = 1'b1;
    run_frame(2'h3, 4000, 1, ccd_timing_pkg::MODE_OUT1, ccd_timing_pkg::LINE_CYC_SINGLE,
              ccd_timing_pkg::IMAGE_PIX_SINGLE);
    run_frame(2'h1, 3500, 0, ccd_timing_pkg::MODE_OUT2, ccd_timing_pkg::LINE_CYC_SINGLE,
              ccd_timing_pkg::IMAGE_PIX_SINGLE);
    run_frame(2'h2, 100, 2, ccd_timing_pkg::MODE_DUAL, ccd_timing_pkg::LINE_CYC_DUAL,
              ccd_timing_pkg::IMAGE_PIX_DUAL);
    summarize();
  end
endmodule : tb_top
